// ---- src/pmfc_pkg.sv ----
// Constants shared by the power-management and queue-count register block.
// Assumes a 50 MHz system clock and an 8-bit register address space.
package pmfc_pkg;

  // Register offsets
  localparam logic [7:0] PWR1_OFFSET      = 8'h6B;
  localparam logic [7:0] PWR2_OFFSET      = 8'h6C;
  localparam logic [7:0] CNT_HIGH_OFFSET  = 8'h72;
  localparam logic [7:0] CNT_LOW_OFFSET   = 8'h73;

  // First power register fields
  localparam int         RESTORE_BIT      = 7;
  localparam int         SLEEP_BIT        = 6;
  localparam int         CYCLE_BIT        = 5;
  localparam int         STANDBY_BIT      = 4;
  localparam int         THERMAL_OFF_BIT  = 3;
  localparam int         CLOCK_SOURCE_SELECT_LSB       = 0;
  localparam int         CLOCK_SOURCE_SELECT_W         = 3;

  // Second power register fields
  localparam int         QUEUE_WAKE_BIT   = 7;
  localparam int         ACCEL_OFF_LSB    = 3;
  localparam int         RATE_OFF_LSB     = 0;
  localparam int         AXES             = 3;

  // Reset values
  localparam logic [7:0] PWR1_RESET_VAL   = 8'h01;
  localparam logic [7:0] PWR2_RESET_VAL   = 8'h00;

  // Clock selector codes
  localparam logic [2:0] CLK_OSC_LOW      = 3'h0;
  localparam logic [2:0] CLK_OSC_HIGH     = 3'h6;
  localparam logic [2:0] CLK_STOP         = 3'h7;

  // Queue byte count
  localparam int         COUNT_W          = 13;
  localparam int         COUNT_HIGH_W     = 5;

  // Timing
  localparam int         CLK_FREQ_MHZ     = 50;
  localparam int         RESTORE_TIME_NS  = 100;
  localparam int         RESTORE_CYCLES   = (RESTORE_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int         RESTORE_CNT_W    = 4;

  typedef enum logic [1:0]
  {
    CYC_OFF,
    CYC_SLEEP,
    CYC_SAMPLE
  } pmfc_cycle_e;

endpackage : pmfc_pkg

// ---- src/pmfc_clk_if.sv ----
// Carrier between the register block and its clock-source selector.
// Assumes both ends sit on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface pmfc_clk_if;
  logic [2:0] clkCode;
  logic       pllReady;
  logic       runOnPll;
  logic       runOnOsc;
  logic       clockStopped;

  modport regs
  (
    output clkCode,
    output pllReady,
    input  runOnPll,
    input  runOnOsc,
    input  clockStopped
  );

  modport sel
  (
    input  clkCode,
    input  pllReady,
    output runOnPll,
    output runOnOsc,
    output clockStopped
  );
endinterface : pmfc_clk_if
`default_nettype wire

// ---- src/pmfc_clock_select.sv ----
// Clock-source selector driven by the three-bit selector field.
// Assumes a synchronous pllReady level from the PLL.
`timescale 1ns/1ps
`default_nettype none
module pmfc_clock_select
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Selector link
  pmfc_clk_if.sel   clkIf
);
  import pmfc_pkg::*;

  logic runOnPll_d;
  logic runOnPll_q;
  logic runOnOsc_d;
  logic runOnOsc_q;
  logic stopped_d;
  logic stopped_q;

  always_comb
  begin
    runOnPll_d = 1'b0;
    runOnOsc_d = 1'b0;
    stopped_d  = 1'b0;
    case (clkIf.clkCode)
      CLK_OSC_LOW, CLK_OSC_HIGH:
        runOnOsc_d = 1'b1;
      CLK_STOP:
        stopped_d = 1'b1;
      default:
      begin
        // Falls back to the oscillator until the PLL locks
        runOnPll_d = clkIf.pllReady;
        runOnOsc_d = !clkIf.pllReady;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      runOnPll_q <= 1'b0;
      runOnOsc_q <= 1'b1;
      stopped_q  <= 1'b0;
    end
    else
    begin
      runOnPll_q <= runOnPll_d;
      runOnOsc_q <= runOnOsc_d;
      stopped_q  <= stopped_d;
    end
  end

  assign clkIf.runOnPll     = runOnPll_q;
  assign clkIf.runOnOsc     = runOnOsc_q;
  assign clkIf.clockStopped = stopped_q;

  chk_osc_codes_select: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clkIf.clkCode == 3'h0 || clkIf.clkCode == 3'h6) |=> runOnOsc_q && !runOnPll_q)
    else $error("Oscillator code did not select the oscillator");

  chk_auto_pll_choice: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clkIf.clkCode >= 3'h1 && clkIf.clkCode <= 3'h5)
      |=> (runOnPll_q == $past(clkIf.pllReady)) && (runOnOsc_q != runOnPll_q))
    else $error("Automatic code chose the wrong source");

  chk_stop_holds_timing: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (clkIf.clkCode == 3'h7) |=> stopped_q && !runOnOsc_q && !runOnPll_q)
    else $error("Stop code left a clock running");

endmodule : pmfc_clock_select
`default_nettype wire

// ---- src/pmfc_power_regs.sv ----
// Power-management and queue byte-count registers of a motion sensor.
// Assumes single-cycle read/write strobes from the serial register port,
// a 13-bit byte count from the queue, and a wake tick from the rate generator.
// What this block does
// - Writing one to the restore bit resets both power registers to defaults, then the bit self-clears.
// - Sleep bit puts the chip to sleep; resets to zero.
// - Cycle bit without sleep or standby alternates sleeping and one accel sample.
// - Cycling with all accel axes off wakes on schedule but takes no sample.
// - Gyro standby keeps drive and PLL running, sense paths off.
// - Thermal off bit turns the temperature sensor off.
// - Selector codes 0 and 6 pick the internal oscillator.
// - Codes 1 to 5 pick the PLL when ready, else the oscillator.
// - Code 7 stops the clock and holds the timing generator in reset.
// - Selector field resets to 001, automatic source choice.
// - Queue-in-wake-mode bit enables the queue during motion wake; resets zero.
// - Second register bits 5..3 switch off X, Y, Z accel axes.
// - Second register bits 2..0 switch off X, Y, Z gyro axes.
// - Count high shows count bits 12..8 in 4..0; bits 7..5 reserved.
// - Count low shows count bits 7..0.
// - Reading count high snapshots the whole count for both bytes.
`timescale 1ns/1ps
`default_nettype none
module pmfc_power_regs
(
  // Clock and reset
  input  wire  logic                         clk_sys,
  input  wire  logic                         sys_rst,
  // Register port
  input  wire  logic [7:0]                   regAddr,
  input  wire  logic                         regWrEn,
  input  wire  logic [7:0]                   regWrData,
  input  wire  logic                         regRdEn,
  output logic       [7:0]                   regRdData,
  output logic                               regRdValid,
  // Queue, sampling and PLL status
  input  wire  logic [pmfc_pkg::COUNT_W-1:0] queueByteCount,
  input  wire  logic                         wakeTick,
  input  wire  logic                         sampleDone,
  input  wire  logic                         pllReady,
  // Power controls
  output logic                               deviceRestore,
  output logic                               sleepMode,
  output logic                               cycleWake,
  output logic                               accelSampleStart,
  output logic                               accelActive,
  output logic [pmfc_pkg::AXES-1:0]          accelAxisOn,
  output logic [pmfc_pkg::AXES-1:0]          gyroSenseOn,
  output logic                               gyroDriveOn,
  output logic                               pllEnable,
  output logic                               thermalSensorOn,
  output logic                               queueInWakeModeEnable,
  // Clock source
  output logic                               runOnPll,
  output logic                               runOnOsc,
  output logic                               timingGenReset
);
  import pmfc_pkg::*;

  // Configuration and restore state
  logic [6:0]               pwr1_d;
  logic [6:0]               pwr1_q;
  logic [7:0]               pwr2_d;
  logic [7:0]               pwr2_q;
  logic                     restoreBusy_d;
  logic                     restoreBusy_q;
  logic [RESTORE_CNT_W-1:0] restoreCnt_d;
  logic [RESTORE_CNT_W-1:0] restoreCnt_q;

  // Read path and count snapshot
  logic [7:0]               rdData_d;
  logic [7:0]               rdData_q;
  logic                     rdValid_d;
  logic                     rdValid_q;
  logic [COUNT_W-1:0]       countSnap_d;
  logic [COUNT_W-1:0]       countSnap_q;

  // Cycle sequencer
  pmfc_cycle_e              cycState_d;
  pmfc_cycle_e              cycState_q;
  logic                     cycleWake_d;
  logic                     cycleWake_q;
  logic                     sampleStart_d;
  logic                     sampleStart_q;

  // Registered power enables
  logic [AXES-1:0]          accelOn_d;
  logic [AXES-1:0]          accelOn_q;
  logic [AXES-1:0]          gyroSense_d;
  logic [AXES-1:0]          gyroSense_q;
  logic                     gyroDrive_d;
  logic                     gyroDrive_q;
  logic                     thermalOn_d;
  logic                     thermalOn_q;

  logic                     sleepBit;
  logic                     cycleBit;
  logic                     standbyBit;
  logic                     cycleEnable;
  logic                     anyAccelOn;
  logic                     wrPwr1;
  logic                     restoreReq;

  pmfc_clk_if clkIf ();

  assign sleepBit    = pwr1_q[SLEEP_BIT];
  assign cycleBit    = pwr1_q[CYCLE_BIT];
  assign standbyBit  = pwr1_q[STANDBY_BIT];
  assign cycleEnable = cycleBit && !sleepBit && !standbyBit;
  assign anyAccelOn  = ~&pwr2_q[ACCEL_OFF_LSB +: AXES];
  // Writes landing during a restore are dropped so defaults stay intact
  assign wrPwr1      = regWrEn && !restoreBusy_q && (regAddr == PWR1_OFFSET);
  assign restoreReq  = wrPwr1 && regWrData[RESTORE_BIT];

  // Configuration registers and restore sequence
  always_comb
  begin
    pwr1_d        = pwr1_q;
    pwr2_d        = pwr2_q;
    restoreBusy_d = restoreBusy_q;
    restoreCnt_d  = restoreCnt_q;
    if (restoreBusy_q)
    begin
      if (restoreCnt_q == RESTORE_CNT_W'(1))
        restoreBusy_d = 1'b0;
      restoreCnt_d = restoreCnt_q - RESTORE_CNT_W'(1);
    end
    else if (restoreReq)
    begin
      pwr1_d        = PWR1_RESET_VAL[6:0];
      pwr2_d        = PWR2_RESET_VAL;
      restoreBusy_d = 1'b1;
      restoreCnt_d  = RESTORE_CNT_W'(RESTORE_CYCLES);
    end
    else if (wrPwr1)
      pwr1_d = regWrData[6:0];
    else if (regWrEn && regAddr == PWR2_OFFSET)
      pwr2_d = {regWrData[QUEUE_WAKE_BIT], 1'b0, regWrData[5:0]};
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pwr1_q        <= PWR1_RESET_VAL[6:0];
      pwr2_q        <= PWR2_RESET_VAL;
      restoreBusy_q <= 1'b0;
      restoreCnt_q  <= '0;
    end
    else
    begin
      pwr1_q        <= pwr1_d;
      pwr2_q        <= pwr2_d;
      restoreBusy_q <= restoreBusy_d;
      restoreCnt_q  <= restoreCnt_d;
    end
  end

  // Register reads; high read returns the live count and latches it
  always_comb
  begin
    rdData_d    = 8'h00;
    rdValid_d   = regRdEn;
    countSnap_d = countSnap_q;
    if (regRdEn)
    begin
      case (regAddr)
        PWR1_OFFSET:
          rdData_d = {restoreBusy_q, pwr1_q};
        PWR2_OFFSET:
          rdData_d = pwr2_q;
        CNT_HIGH_OFFSET:
        begin
          rdData_d    = {3'h0, queueByteCount[COUNT_W-1 -: COUNT_HIGH_W]};
          countSnap_d = queueByteCount;
        end
        CNT_LOW_OFFSET:
          rdData_d = countSnap_q[7:0];
        default:
          rdData_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rdData_q    <= 8'h00;
      rdValid_q   <= 1'b0;
      countSnap_q <= '0;
    end
    else
    begin
      rdData_q    <= rdData_d;
      rdValid_q   <= rdValid_d;
      countSnap_q <= countSnap_d;
    end
  end

  // Cycled accelerometer sequencer
  always_comb
  begin
    cycState_d    = cycState_q;
    cycleWake_d   = 1'b0;
    sampleStart_d = 1'b0;
    case (cycState_q)
      CYC_OFF:
        if (cycleEnable)
          cycState_d = CYC_SLEEP;
      CYC_SLEEP:
        if (!cycleEnable)
          cycState_d = CYC_OFF;
        else if (wakeTick)
        begin
          cycleWake_d = 1'b1;
          if (anyAccelOn)
          begin
            sampleStart_d = 1'b1;
            cycState_d    = CYC_SAMPLE;
          end
        end
      CYC_SAMPLE:
        // A sample in flight finishes even if cycling is switched off
        if (sampleDone)
          cycState_d = cycleEnable ? CYC_SLEEP : CYC_OFF;
      default:
        cycState_d = CYC_OFF;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cycState_q    <= CYC_OFF;
      cycleWake_q   <= 1'b0;
      sampleStart_q <= 1'b0;
    end
    else
    begin
      cycState_q    <= cycState_d;
      cycleWake_q   <= cycleWake_d;
      sampleStart_q <= sampleStart_d;
    end
  end

  // Power enables of the sensor paths
  always_comb
  begin
    accelOn_d   = ~pwr2_q[ACCEL_OFF_LSB +: AXES] & {AXES{!sleepBit}};
    gyroDrive_d = !sleepBit && !clkIf.clockStopped;
    gyroSense_d = ~pwr2_q[RATE_OFF_LSB +: AXES]
                  & {AXES{gyroDrive_d && !standbyBit}};
    thermalOn_d = !sleepBit && !pwr1_q[THERMAL_OFF_BIT];
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      accelOn_q   <= '0;
      gyroSense_q <= '0;
      gyroDrive_q <= 1'b0;
      thermalOn_q <= 1'b0;
    end
    else
    begin
      accelOn_q   <= accelOn_d;
      gyroSense_q <= gyroSense_d;
      gyroDrive_q <= gyroDrive_d;
      thermalOn_q <= thermalOn_d;
    end
  end

  assign clkIf.clkCode  = pwr1_q[CLOCK_SOURCE_SELECT_LSB +: CLOCK_SOURCE_SELECT_W];
  assign clkIf.pllReady = pllReady;

  pmfc_clock_select u_clock_select
  (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .clkIf   (clkIf.sel)
  );

  assign regRdData             = rdData_q;
  assign regRdValid            = rdValid_q;
  assign deviceRestore         = restoreBusy_q;
  assign sleepMode             = sleepBit;
  assign cycleWake             = cycleWake_q;
  assign accelSampleStart      = sampleStart_q;
  assign accelActive           = (cycState_q == CYC_SAMPLE);
  assign accelAxisOn           = accelOn_q;
  assign gyroSenseOn           = gyroSense_q;
  assign gyroDriveOn           = gyroDrive_q;
  assign pllEnable             = gyroDrive_q;
  assign thermalSensorOn       = thermalOn_q;
  assign queueInWakeModeEnable = pwr2_q[QUEUE_WAKE_BIT];
  assign runOnPll              = clkIf.runOnPll;
  assign runOnOsc              = clkIf.runOnOsc;
  assign timingGenReset        = clkIf.clockStopped;

  chk_restore_self_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    restoreReq |=> restoreBusy_q[*5] ##1 !restoreBusy_q && pwr1_q == 7'h01 && pwr2_q == 8'h00)
    else $error("Restore did not self-clear with defaults");

  chk_sleep_default: assert property (@(posedge clk_sys)
    sys_rst |=> !sleepMode && pwr1_q[2:0] == 3'h1)
    else $error("Sleep or selector reset value wrong");

  chk_cycle_sample: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cycState_q == CYC_SLEEP && cycleEnable && wakeTick && anyAccelOn)
      |=> accelSampleStart && cycleWake && accelActive)
    else $error("Cycle wake did not start a sample");

  chk_no_sample_axes_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (cycState_q == CYC_SLEEP && cycleEnable && wakeTick && !anyAccelOn)
      |=> cycleWake && !accelSampleStart && !accelActive)
    else $error("Sample taken with every accel axis off");

  chk_standby_drive: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (standbyBit && !sleepBit && !clkIf.clockStopped) |=> gyroDriveOn && gyroSenseOn == 3'h0)
    else $error("Gyro standby power state wrong");

  chk_thermal_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pwr1_q[THERMAL_OFF_BIT] |=> !thermalSensorOn)
    else $error("Temperature sensor left on");

  chk_axis_disables: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !sleepBit |=> accelAxisOn == ~$past(pwr2_q[5:3]))
    else $error("Accel axis enables do not follow the register");

  chk_count_snapshot: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (regRdEn && regAddr == CNT_HIGH_OFFSET)
      |=> regRdData[7:5] == 3'h0 && {regRdData[4:0], countSnap_q[7:0]} == countSnap_q)
    else $error("Count high read not coherent with snapshot");

  chk_low_read_stale: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (regRdEn && regAddr == CNT_LOW_OFFSET) |=> $stable(countSnap_q) && regRdData == countSnap_q[7:0])
    else $error("Low count read refreshed the snapshot");

endmodule : pmfc_power_regs
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench for the power-management and queue byte-count registers.
// Assumes the register block is the top, on one 50 MHz clock with synchronous reset.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin fails++; \
  $display("unexpected %s expected %0h seen %0h", nm, ex, gt); end end
module tb_top;
  import pmfc_pkg::*;
  logic             clk_sys;
  logic             sys_rst;
  logic [7:0]       regAddr;
  logic             regWrEn;
  logic [7:0]       regWrData;
  logic             regRdEn;
  logic [7:0]       regRdData;
  logic             regRdValid;
  logic [COUNT_W-1:0] queueByteCount;
  logic             wakeTick;
  logic             sampleDone;
  logic             pllReady;
  logic             deviceRestore;
  logic             sleepMode;
  logic             cycleWake;
  logic             accelSampleStart;
  logic             accelActive;
  logic [AXES-1:0]  accelAxisOn;
  logic [AXES-1:0]  gyroSenseOn;
  logic             gyroDriveOn;
  logic             pllEnable;
  logic             thermalSensorOn;
  logic             queueInWakeModeEnable;
  logic             runOnPll;
  logic             runOnOsc;
  logic             timingGenReset;
  int               fails = 0;
  int               cmp_count = 0;
  int               cycCount = 0;
  int               restHigh = 0;
  int               restBase;
  logic [7:0]       d;
  logic [7:0]       pwrVals [3] = '{8'h41, 8'h09, 8'h11};
  logic [7:0]       axisVals [5] = '{8'hFF, 8'hA4, 8'h12, 8'h09, 8'h00};

  pmfc_power_regs dut
  (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .queueByteCount(queueByteCount), .wakeTick(wakeTick),
    .sampleDone(sampleDone), .pllReady(pllReady), .deviceRestore(deviceRestore),
    .sleepMode(sleepMode), .cycleWake(cycleWake), .accelSampleStart(accelSampleStart),
    .accelActive(accelActive), .accelAxisOn(accelAxisOn), .gyroSenseOn(gyroSenseOn),
    .gyroDriveOn(gyroDriveOn), .pllEnable(pllEnable), .thermalSensorOn(thermalSensorOn),
    .queueInWakeModeEnable(queueInWakeModeEnable), .runOnPll(runOnPll),
    .runOnOsc(runOnOsc), .timingGenReset(timingGenReset)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Restore length measured apart from the stimulus, so writes may overlap it
  always @(posedge clk_sys)
  begin
    cycCount <= cycCount + 1;
    if (deviceRestore === 1'b1)
      restHigh <= restHigh + 1;
    if (cycCount == 5000)
    begin
      fails++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    regAddr   <= a;
    regWrData <= v;
    regWrEn   <= 1'b1;
    @(posedge clk_sys);
    regWrEn   <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] ex, input string nm);
    @(posedge clk_sys);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clk_sys);
    regRdEn <= 1'b0;
    @(negedge clk_sys);
    `CHK({nm, " valid"}, 1'b1, regRdValid)
    `CHK(nm, ex, regRdData)
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle

  // One-cycle pulse on the wake tick or on sample completion
  task automatic tick(input bit w);
    @(posedge clk_sys);
    if (w)
      wakeTick <= 1'b1;
    else
      sampleDone <= 1'b1;
    @(posedge clk_sys);
    wakeTick   <= 1'b0;
    sampleDone <= 1'b0;
    @(negedge clk_sys);
  endtask : tick

  task automatic endTest(input string nm);
    $display("test %s done, mismatches so far %0d", nm, fails);
  endtask : endTest

  initial
  begin
    sys_rst = 1'b1;
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
    queueByteCount = '0;
    wakeTick = 1'b0;
    sampleDone = 1'b0;
    pllReady = 1'b0;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    settle(2);
    `CHK("sleepMode", 1'b0, sleepMode)
    `CHK("runOnOsc", 1'b1, runOnOsc)
    `CHK("accelAxisOn", 3'h7, accelAxisOn)
    rd(PWR1_OFFSET, 8'h01, "pwr1 reset");
    rd(PWR2_OFFSET, 8'h00, "pwr2 reset");
    endTest("reset");

    // Every selector code, with the PLL not ready and then ready
    for (int p = 0; p < 2; p++)
    begin
      for (int c = 0; c < 8; c++)
      begin
        @(posedge clk_sys);
        pllReady <= p[0];
        wr(PWR1_OFFSET, {5'h00, c[2:0]});
        settle(3);
        `CHK("runOnPll", (c inside {[1:5]}) && p == 1, runOnPll)
        `CHK("runOnOsc", c == 0 || c == 6 || ((c inside {[1:5]}) && p == 0), runOnOsc)
        `CHK("timingGenReset", c == 7, timingGenReset)
        `CHK("gyroDriveOn", c != 7, gyroDriveOn)
      end
    end
    endTest("clock select");

    for (int i = 0; i < 3; i++)
    begin
      d = pwrVals[i];
      wr(PWR1_OFFSET, d);
      settle(2);
      `CHK("sleepMode", d[6], sleepMode)
      `CHK("accelAxisOn", d[6] ? 3'h0 : 3'h7, accelAxisOn)
      `CHK("gyroSenseOn", (d[6] | d[4]) ? 3'h0 : 3'h7, gyroSenseOn)
      `CHK("gyroDriveOn", !d[6], gyroDriveOn)
      `CHK("pllEnable", !d[6], pllEnable)
      `CHK("thermalSensorOn", !(d[6] | d[3]), thermalSensorOn)
      rd(PWR1_OFFSET, d, "pwr1 readback");
    end
    wr(PWR1_OFFSET, 8'h01);
    endTest("power bits");

    for (int i = 0; i < 5; i++)
    begin
      d = axisVals[i];
      wr(PWR2_OFFSET, d);
      settle(2);
      `CHK("accelAxisOn", ~d[5:3], accelAxisOn)
      `CHK("gyroSenseOn", ~d[2:0], gyroSenseOn)
      `CHK("queueInWakeModeEnable", d[7], queueInWakeModeEnable)
      rd(PWR2_OFFSET, d & 8'hBF, "pwr2 readback");
    end
    endTest("axis disables");

    @(posedge clk_sys);
    queueByteCount <= 13'h1ABC;
    rd(CNT_HIGH_OFFSET, 8'h1A, "count high");
    @(posedge clk_sys);
    queueByteCount <= 13'h0123;
    rd(CNT_LOW_OFFSET, 8'hBC, "count low latched");
    rd(CNT_LOW_OFFSET, 8'hBC, "count low again");
    rd(CNT_HIGH_OFFSET, 8'h01, "count high new");
    rd(CNT_LOW_OFFSET, 8'h23, "count low new");
    @(posedge clk_sys);
    queueByteCount <= 13'h1FFF;
    wr(CNT_HIGH_OFFSET, 8'h00);
    wr(CNT_LOW_OFFSET, 8'h00);
    rd(CNT_HIGH_OFFSET, 8'h1F, "count high full");
    rd(CNT_LOW_OFFSET, 8'hFF, "count low full");
    rd(8'h10, 8'h00, "unmapped");
    endTest("byte count");

    wr(PWR2_OFFSET, 8'h00);
    wr(PWR1_OFFSET, 8'h20);
    settle(2);
    tick(1'b1);
    `CHK("cycleWake", 1'b1, cycleWake)
    `CHK("accelSampleStart", 1'b1, accelSampleStart)
    `CHK("accelActive", 1'b1, accelActive)
    settle(0);
    `CHK("cycleWake pulse", 1'b0, cycleWake)
    tick(1'b0);
    `CHK("accelActive done", 1'b0, accelActive)
    wr(PWR2_OFFSET, 8'h38);
    settle(2);
    tick(1'b1);
    `CHK("cycleWake no axes", 1'b1, cycleWake)
    `CHK("accelSampleStart no axes", 1'b0, accelSampleStart)
    wr(PWR2_OFFSET, 8'h00);
    // Sleep or gyro standby alongside the cycle bit blocks cycling
    for (int i = 0; i < 2; i++)
    begin
      wr(PWR1_OFFSET, i == 0 ? 8'h60 : 8'h30);
      settle(2);
      tick(1'b1);
      `CHK("cycleWake blocked", 1'b0, cycleWake)
    end
    endTest("cycled mode");

    wr(PWR2_OFFSET, 8'h3F);
    wr(PWR1_OFFSET, 8'h48);
    @(negedge clk_sys);
    restBase = restHigh;
    wr(PWR1_OFFSET, 8'h80);
    @(negedge clk_sys);
    `CHK("deviceRestore", 1'b1, deviceRestore)
    wr(PWR2_OFFSET, 8'h38);
    for (int i = 0; i < 20 && deviceRestore !== 1'b0; i++)
      @(negedge clk_sys);
    settle(1);
    `CHK("restore length", RESTORE_CYCLES, restHigh - restBase)
    `CHK("sleepMode restored", 1'b0, sleepMode)
    rd(PWR1_OFFSET, 8'h01, "pwr1 restored");
    rd(PWR2_OFFSET, 8'h00, "pwr2 restored");
    endTest("restore");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
